// ===== logic/wake_attach_top.sv
/*
 * Wake request and attach ready pin controller with a small register file and interrupt.
 * Assumes event inputs are one-cycle pulses synchronous to mclk, and the nonvolatile
 * configuration bytes are stable when reset is released.
 */
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "wake_attach_regs.svh"
module wake_attach_top #(
	parameter int unsigned PULSE_SHORT_CYC = `PULSE_SHORT_CYC,
	parameter int unsigned PULSE_LONG_CYC  = `PULSE_LONG_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        we,
	input  wire logic        re,
	output logic      [31:0] rdata,
	output logic             irq,
	input  wire logic [7:0]  nvm_flags0,
	input  wire logic [7:0]  nvm_flags1,
	input  wire logic        link_change_evt,
	input  wire logic        packet_evt,
	input  wire logic        exact_address_match_evt,
	input  wire logic        broadcast_evt,
	input  wire logic        wakeup_frame_filter_evt,
	input  wire logic        udc_ready,
	input  wire logic        hsic_mode,
	output logic             wakeup_frame_filter0_en,
	output logic             wake_request_pin_o,
	output logic             wake_request_pin_oe,
	output logic             attach_pin_o,
	output logic             attach_pin_oe
);
	wake_attach_pkg::top_state_t s_q;
	wake_attach_pkg::top_state_t s_d;

	pulse_if tmr ();

	logic [4:0] wake_src;
	logic [4:0] wake_en;
	logic       master;
	logic       wake_evt;
	logic       wake_active;
	logic       att_en;
	logic       att_active;
	logic       clear_wr;
	logic [1:0] events;
	logic [1:0] rd_clr;
	logic       start;
	logic [7:0] f0;
	logic [7:0] f1;

	wake_pulse_timer #(
		.SHORT_CYC (PULSE_SHORT_CYC),
		.LONG_CYC  (PULSE_LONG_CYC)
	) u_timer (
		.mclk (mclk),
		.rst  (rst),
		.tmr  (tmr)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Returns {out, enable}; a disabled pin is released and open drain never drives high.
	function automatic logic [1:0] drive(input logic act, input logic pol, input logic pp, input logic en);
		logic lvl;
		lvl = act ? pol : ~pol;
		if (!en)
			return 2'b00;
		else if (pp)
			return {lvl, 1'b1};
		else
			return {1'b0, ~lvl};
	endfunction

	assign f0 = s_q.flags0;
	assign f1 = s_q.flags1;

	always_comb
	begin
		s_d = s_q;
		master = f0[`F0_MASTER];
		wake_src = {wakeup_frame_filter_evt, broadcast_evt, exact_address_match_evt, packet_evt, link_change_evt};
		wake_en = {f1[`F1_FRAME_FILTER], f1[`F1_BCAST], f0[`F0_EXACT], f0[`F0_PKT], f0[`F0_LINK]};
		wake_evt = master && |(wake_src & wake_en);
		clear_wr = we && hit(addr, `REG_CTRL) && wdata[`CTRL_CLEAR];
		start = 1'b0;
		rd_clr = 2'b00;

		case (s_q.wstate)
			wake_attach_pkg::WAKE_IDLE:
			begin
				if (wake_evt)
				begin
					if (f0[`F0_FORM])
					begin
						start = 1'b1;
						s_d.wstate = wake_attach_pkg::WAKE_PULSE;
					end
					else
						s_d.wstate = wake_attach_pkg::WAKE_LEVEL;
				end
			end
			wake_attach_pkg::WAKE_LEVEL:
			begin
				if (clear_wr || !master)
					s_d.wstate = wake_attach_pkg::WAKE_IDLE;
			end
			wake_attach_pkg::WAKE_PULSE:
			begin
				if (!tmr.busy)
					s_d.wstate = wake_attach_pkg::WAKE_IDLE;
			end
			default:
				s_d.wstate = wake_attach_pkg::WAKE_IDLE;
		endcase

		// A pulse is active only while the timer runs, so the pin holds for exactly the counted cycles.
		wake_active = (s_q.wstate == wake_attach_pkg::WAKE_LEVEL) ||
			(s_q.wstate == wake_attach_pkg::WAKE_PULSE && tmr.busy);
		{s_d.wake_o, s_d.wake_oe} = drive(wake_active, f0[`F0_POL], f0[`F0_PP], master);

		att_en = hsic_mode && f1[`F1_ATT_EN];
		att_active = att_en && udc_ready;
		{s_d.att_o, s_d.att_oe} = drive(udc_ready, f1[`F1_ATT_POL], f1[`F1_ATT_PP], att_en);
		s_d.att_prev = att_active;

		events = {att_active && !s_q.att_prev, wake_evt};
		if (re && hit(addr, `REG_STATUS))
			rd_clr = 2'b11;
		// A new event in the clearing cycle survives the read.
		s_d.status = (s_q.status & ~rd_clr) | events;

		if (we)
		begin
			if (hit(addr, `REG_FLAGS))
			begin
				s_d.flags0 = wdata[7:0];
				s_d.flags1 = wdata[15:8] & `F1_WRITE_MASK;
			end
			else if (hit(addr, `REG_MASK))
				s_d.mask = wdata[1:0];
		end

		if (!s_q.loaded)
		begin
			s_d.flags0 = nvm_flags0;
			s_d.flags1 = nvm_flags1 & `F1_WRITE_MASK;
			s_d.loaded = 1'b1;
		end

		s_d.rdata = 32'h0000_0000;
		if (re)
		begin
			if (hit(addr, `REG_FLAGS))
				s_d.rdata = {16'h0000, f1, f0};
			else if (hit(addr, `REG_STATUS))
				s_d.rdata = {30'h0000_0000, s_q.status};
			else if (hit(addr, `REG_MASK))
				s_d.rdata = {30'h0000_0000, s_q.mask};
			else if (hit(addr, `REG_CTRL))
				s_d.rdata = {29'h0000_0000, tmr.busy, att_active, wake_active};
		end

		s_d.irq = |(s_d.status & s_d.mask);
	end

	assign tmr.start = start;
	assign tmr.long_sel = f0[`F0_LEN];

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rdata = s_q.rdata;
	assign irq = s_q.irq;
	assign wake_request_pin_o = s_q.wake_o;
	assign wake_request_pin_oe = s_q.wake_oe;
	assign attach_pin_o = s_q.att_o;
	assign attach_pin_oe = s_q.att_oe;
	assign wakeup_frame_filter0_en = f1[`F1_FRAME_FILTER];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_master_off;
		!f0[`F0_MASTER] |=> !wake_request_pin_oe;
	endproperty
	a_master_off: assert property (p_master_off) else $error("Wake pin driven with master off.");

	property p_master_gate;
		wake_evt |-> f0[`F0_MASTER];
	endproperty
	a_master_gate: assert property (p_master_gate) else $error("Wake event with master off.");

	property p_pulse_form;
		s_q.wstate == wake_attach_pkg::WAKE_IDLE && wake_evt && f0[`F0_FORM] |=> tmr.busy ##1 tmr.busy;
	endproperty
	a_pulse_form: assert property (p_pulse_form) else $error("Pulse mode did not start timer.");

	property p_level_hold;
		s_q.wstate == wake_attach_pkg::WAKE_LEVEL && f0[`F0_MASTER] && !clear_wr |=> s_q.wstate == wake_attach_pkg::WAKE_LEVEL;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("Wake level dropped early.");

	property p_pol_pp;
		f0[`F0_MASTER] && f0[`F0_PP] |=>
			wake_request_pin_oe && wake_request_pin_o == ($past(wake_active) ? $past(f0[`F0_POL]) : !$past(f0[`F0_POL]));
	endproperty
	a_pol_pp: assert property (p_pol_pp) else $error("Push-pull wake level wrong.");

	property p_open_drain;
		f0[`F0_MASTER] && !f0[`F0_PP] |=> !wake_request_pin_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("Open-drain wake pin drove high.");

	property p_link_off;
		!f0[`F0_LINK] && wake_src == 5'h01 |-> !wake_evt;
	endproperty
	a_link_off: assert property (p_link_off) else $error("Link change woke while disabled.");

	property p_packet_on;
		packet_evt && f0[`F0_PKT] && f0[`F0_MASTER] |-> wake_evt;
	endproperty
	a_packet_on: assert property (p_packet_on) else $error("Packet wake missed.");

	property p_exact_on;
		exact_address_match_evt && f0[`F0_EXACT] && f0[`F0_MASTER] |-> wake_evt;
	endproperty
	a_exact_on: assert property (p_exact_on) else $error("Exact address wake missed.");

	property p_bcast_off;
		!f1[`F1_BCAST] && wake_src == 5'h08 |-> !wake_evt;
	endproperty
	a_bcast_off: assert property (p_bcast_off) else $error("Broadcast woke while disabled.");

	property p_filter_on;
		wakeup_frame_filter_evt && f1[`F1_FRAME_FILTER] && f0[`F0_MASTER] |-> wake_evt;
	endproperty
	a_filter_on: assert property (p_filter_on) else $error("Wakeup frame wake missed.");

	property p_attach_on;
		hsic_mode && f1[`F1_ATT_EN] && f1[`F1_ATT_PP] && udc_ready |=> attach_pin_oe && attach_pin_o == $past(f1[`F1_ATT_POL]);
	endproperty
	a_attach_on: assert property (p_attach_on) else $error("Attach pin level wrong.");

	property p_attach_od;
		hsic_mode && f1[`F1_ATT_EN] && !f1[`F1_ATT_PP] |=> !attach_pin_o;
	endproperty
	a_attach_od: assert property (p_attach_od) else $error("Open-drain attach pin drove high.");

	property p_attach_off;
		!hsic_mode || !f1[`F1_ATT_EN] |=> !attach_pin_oe;
	endproperty
	a_attach_off: assert property (p_attach_off) else $error("Attach pin driven while disabled.");

	property p_defaults;
		!s_q.loaded |=> s_q.flags0 == $past(nvm_flags0) && s_q.flags1 == ($past(nvm_flags1) & `F1_WRITE_MASK);
	endproperty
	a_defaults: assert property (p_defaults) else $error("Defaults not loaded.");

	property p_irq;
		s_q.status[`ST_WAKE] && s_q.mask[`ST_WAKE] |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt missing.");

	c_pulse: cover property (start ##1 tmr.busy);
	c_level: cover property (s_q.wstate == wake_attach_pkg::WAKE_LEVEL ##1 clear_wr);
	c_attach: cover property (att_active && !s_q.att_prev);
	c_irq: cover property ($rose(irq));
endmodule

// ===== pkg/wake_attach_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the wake and attach block.
 * Assumes a 200 MHz mclk and an 8-bit register address bus.
 */
`ifndef WAKE_ATTACH_REGS_SVH
`define WAKE_ATTACH_REGS_SVH

`define REG_FLAGS        8'h00
`define REG_STATUS       8'h04
`define REG_MASK         8'h08
`define REG_CTRL         8'h0c

`define F0_MASTER        7
`define F0_FORM          6
`define F0_LEN           5
`define F0_POL           4
`define F0_PP            3
`define F0_LINK          2
`define F0_PKT           1
`define F0_EXACT         0
`define F1_ATT_PP        6
`define F1_ATT_EN        5
`define F1_ATT_POL       4
`define F1_BCAST         1
`define F1_FRAME_FILTER  0
`define F1_WRITE_MASK    8'h73

`define ST_WAKE          0
`define ST_ATTACH        1
`define CTRL_CLEAR       0

`define FLAGS_RST        8'h00

`define CLK_PERIOD_NS    5
`define PULSE_SHORT_NS   1500000
`define PULSE_LONG_NS    150000000
`define PULSE_SHORT_CYC  (`PULSE_SHORT_NS / `CLK_PERIOD_NS)
`define PULSE_LONG_CYC   (`PULSE_LONG_NS / `CLK_PERIOD_NS)
`define TIMER_W          25

`endif

// ===== pkg/wake_attach_pkg.sv
/*
 * Types of the wake and attach block.
 * Assumes wake_attach_regs.svh is on the include path.
 */
`include "wake_attach_regs.svh"
package wake_attach_pkg;
	typedef enum logic [1:0] {WAKE_IDLE, WAKE_LEVEL, WAKE_PULSE} wake_state_t;

	typedef struct packed {
		logic [`TIMER_W-1:0] cnt;
		logic                busy;
	} timer_state_t;

	typedef struct packed {
		logic [7:0]  flags0;
		logic [7:0]  flags1;
		logic        loaded;
		wake_state_t wstate;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic        att_prev;
		logic        wake_o;
		logic        wake_oe;
		logic        att_o;
		logic        att_oe;
		logic        irq;
		logic [31:0] rdata;
	} top_state_t;
endpackage

// ===== pkg/pulse_if.sv
/*
 * Interface between the wake controller and its pulse timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pulse_if;
	logic start;
	logic long_sel;
	logic busy;
	modport timer (input start, input long_sel, output busy);
	modport ctl   (output start, output long_sel, input busy);
endinterface

// ===== logic/wake_pulse_timer.sv
/*
 * One-shot timer that holds busy for a fixed number of cycles after start.
 * Assumes start is ignored while busy, so later wake events do not stretch the pulse.
 */
`timescale 1ns/1ps
`include "wake_attach_regs.svh"
module wake_pulse_timer #(
	parameter int unsigned SHORT_CYC = `PULSE_SHORT_CYC,
	parameter int unsigned LONG_CYC  = `PULSE_LONG_CYC
) (
	input  wire logic mclk,
	input  wire logic rst,
	pulse_if.timer    tmr
);
	wake_attach_pkg::timer_state_t s_q;
	wake_attach_pkg::timer_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (tmr.start && !s_q.busy)
		begin
			s_d.busy = 1'b1;
			s_d.cnt  = tmr.long_sel ? `TIMER_W'(LONG_CYC - 1) : `TIMER_W'(SHORT_CYC - 1);
		end
		else if (s_q.busy)
		begin
			if (s_q.cnt == '0)
				s_d.busy = 1'b0;
			else
				s_d.cnt = s_q.cnt - `TIMER_W'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tmr.busy = s_q.busy;

	property p_pulse_load;
		@(posedge mclk) disable iff (rst)
		$rose(s_q.busy) |-> s_q.cnt == ($past(tmr.long_sel) ? `TIMER_W'(LONG_CYC - 1) : `TIMER_W'(SHORT_CYC - 1));
	endproperty
	a_pulse_load: assert property (p_pulse_load) else $error("Pulse length loaded wrong.");

	property p_pulse_end;
		@(posedge mclk) disable iff (rst)
		s_q.busy && s_q.cnt == '0 |=> !s_q.busy;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("Pulse did not end at count zero.");
endmodule

// ===== test/host_pin_model.sv
/*
 * Host side of the wake and attach pins: resolves each pin to the level on its wire.
 * Assumes the host fits a pull-up on both pins, so a released pin reads high.
 */
`timescale 1ns/1ps
module host_pin_model (
	input  wire logic wake_o,
	input  wire logic wake_oe,
	input  wire logic att_o,
	input  wire logic att_oe,
	output logic      wake_wire,
	output logic      att_wire
);
	// A released pin goes to the pull-up level, never to its last driven value.
	assign wake_wire = wake_oe ? wake_o : 1'b1;
	assign att_wire  = att_oe ? att_o : 1'b1;
endmodule

// ===== test/tb_top.sv
/*
 * Self-checking bench for the wake and attach controller.
 * Assumes shortened pulse counts of 20 and 40 cycles and a pulled-up host side.
 */
`timescale 1ns/1ps
module tb_top;
	logic        mclk;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        we;
	logic        re;
	logic [31:0] rdata;
	logic        irq;
	logic [4:0]  evt;
	logic        udc_ready;
	logic        hsic_mode;
	logic        filter0_en;
	logic        wk_o, wk_oe, at_o, at_oe, wk_w, at_w;
	logic        re_q;
	logic [31:0] notes[$];
	int          num_errors;
	int          compares;
	int          src_bit[5] = '{2, 1, 0, 9, 8};

	wake_attach_top #(.PULSE_SHORT_CYC(20), .PULSE_LONG_CYC(40)) wake_attach_top_i (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .irq(irq),
		.nvm_flags0(8'hc7), .nvm_flags1(8'h73), .link_change_evt(evt[0]), .packet_evt(evt[1]),
		.exact_address_match_evt(evt[2]), .broadcast_evt(evt[3]), .wakeup_frame_filter_evt(evt[4]),
		.udc_ready(udc_ready), .hsic_mode(hsic_mode), .wakeup_frame_filter0_en(filter0_en),
		.wake_request_pin_o(wk_o), .wake_request_pin_oe(wk_oe), .attach_pin_o(at_o), .attach_pin_oe(at_oe)
	);

	host_pin_model host_pin_model_i (
		.wake_o(wk_o), .wake_oe(wk_oe), .att_o(at_o), .att_oe(at_oe), .wake_wire(wk_w), .att_wire(at_w)
	);

	task automatic results;
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		notes.push_back(e);
		@(posedge mclk);
		re <= 1'b1;
		addr <= a;
		@(posedge mclk);
		re <= 1'b0;
	endtask

	task automatic fire(input logic [4:0] m);
		@(posedge mclk);
		evt <= m;
		@(posedge mclk);
		evt <= 5'h00;
	endtask

	// Compares drive enable and wire level of the wake pin against the flags0 setting.
	task automatic pin_chk(input logic act, input logic [7:0] cfg);
		logic lvl;
		lvl = act ? cfg[4] : !cfg[4];
		if (!cfg[7])
			chk({wk_oe, wk_w}, 2'b01);
		else
			chk({wk_oe, wk_w}, {cfg[3] | !lvl, lvl});
	endtask

	// Follows a pulse from its first active cycle, re-firing part way to show it is not stretched.
	task automatic pulse_chk(input int n, input logic [7:0] cfg, input logic [4:0] again);
		@(posedge mclk);
		#1;
		for (int k = 0; k < n; k++)
		begin
			pin_chk(1'b1, cfg);
			@(posedge mclk);
			if (k == 3)
				evt <= again;
			if (k == 4)
				evt <= 5'h00;
			#1;
		end
		pin_chk(1'b0, cfg);
	endtask

	initial
	begin
		mclk = 1'b0;
		forever
			#2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		if (re_q)
			chk(rdata, notes.pop_front());
		re_q = re;
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		results();
	end

	initial
	begin
		logic [7:0] cfg;
		logic       lvl;
		logic [1:0] e;
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		we = 1'b0;
		re = 1'b0;
		re_q = 1'b0;
		evt = 5'h00;
		udc_ready = 1'b0;
		hsic_mode = 1'b0;
		num_errors = 0;
		compares = 0;
		void'($urandom(34));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		chk(filter0_en, 32'h1);
		rd(8'h00, 32'h0000_73c7);
		#1;
		pin_chk(1'b0, 8'hc7);
		wr(8'h08, 32'h1);
		fire(5'h01);
		pulse_chk(20, 8'hc7, 5'h01);
		chk(irq, 32'h1);
		rd(8'h04, 32'h1);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h1);
		#1;
		chk(irq, 32'h0);
		wr(8'h10, 32'hffff_ffff);
		rd(8'h10, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h00, 32'hd8);
			fire(5'h01 << i);
			repeat (4)
			begin
				@(posedge mclk);
				#1;
				pin_chk(1'b0, 8'hd8);
			end
			wr(8'h00, 32'hd8 | (32'h1 << src_bit[i]));
			fire(5'h01 << i);
			pulse_chk(20, 8'hd8, 5'h00);
		end
		wr(8'h00, 32'hfc);
		fire(5'h01);
		pulse_chk(40, 8'hfc, 5'h00);
		wr(8'h00, 32'h94);
		fire(5'h01);
		repeat (50) @(posedge mclk);
		#1;
		pin_chk(1'b1, 8'h94);
		wr(8'h0c, 32'h1);
		@(posedge mclk);
		#1;
		pin_chk(1'b0, 8'h94);
		rd(8'h04, 32'h1);
		wr(8'h00, 32'h037f);
		fire(5'h1f);
		repeat (25)
		begin
			@(posedge mclk);
			#1;
			pin_chk(1'b0, 8'h7f);
		end
		rd(8'h04, 32'h0);
		repeat (16)
		begin
			cfg = 8'($urandom);
			wr(8'h00, {16'h0, 1'b0, cfg[2:0], 4'h0, 8'h00});
			@(posedge mclk);
			hsic_mode <= cfg[3];
			udc_ready <= cfg[4];
			repeat (3) @(posedge mclk);
			#1;
			lvl = cfg[4] ? cfg[0] : !cfg[0];
			e = cfg[2] ? {1'b1, lvl} : {!lvl, 1'b0};
			if (!(cfg[3] & cfg[1]))
				e = 2'b00;
			chk({at_oe, at_o}, e);
			chk(at_w, e[1] ? e[0] : 1'b1);
		end
		repeat (2) @(posedge mclk);
		results();
	end
endmodule
